//--- rmst_seg_xlat.sv
/*
  Segment translation top: operating mode, ten segment registers and
  linear address formation with one cycle of latency.
  Assumes request and load inputs are synchronous single-cycle strobes
  from the execution path; descriptor contents arrive ready-made.
*/
`default_nettype none

module rmst_seg_xlat (
  // clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     rst_n_in,
  // mode control
  input  wire rmst_pkg::rmst_mode_req_s mode_req_in,
  input  wire logic                     intr_in,
  // segment loads
  input  wire rmst_pkg::rmst_ld_s       seg_ld_in,
  // translation
  input  wire rmst_pkg::rmst_xlat_req_s xlat_req_in,
  output var  rmst_pkg::rmst_xlat_rsp_s xlat_rsp_out,
  // status
  output var  rmst_pkg::rmst_mode_e     mode_out,
  output logic                          mode_refused_out,
  output logic                          ld_refused_out
);

  // -----------------------------------------------------------------
  // mode state
  // -----------------------------------------------------------------
  rmst_pkg::rmst_mode_e mode_reg;
  rmst_pkg::rmst_mode_e mode_next;
  logic                 req_legal;
  logic                 mode_refused_reg;
  logic                 mode_refused_next;

  always_comb begin
    req_legal = 1'b0;
    unique case (mode_reg)
      rmst_pkg::MODE_REAL:
        req_legal = mode_req_in.target == rmst_pkg::MODE_PROT;
      rmst_pkg::MODE_PROT:
        req_legal = mode_req_in.target != rmst_pkg::MODE_LONG64;
      rmst_pkg::MODE_V86:
        req_legal = mode_req_in.target == rmst_pkg::MODE_PROT;
      rmst_pkg::MODE_COMPAT:
        req_legal = mode_req_in.target == rmst_pkg::MODE_PROT ||
                    mode_req_in.target == rmst_pkg::MODE_LONG64;
      rmst_pkg::MODE_LONG64:
        req_legal = mode_req_in.target == rmst_pkg::MODE_COMPAT;
      default:
        req_legal = 1'b0;
    endcase
  end

  always_comb begin
    mode_next         = mode_reg;
    mode_refused_next = 1'b0;
    if (mode_reg == rmst_pkg::MODE_V86 && intr_in) begin
      mode_next = rmst_pkg::MODE_PROT;
    end else if (mode_req_in.valid) begin
      if (req_legal) begin
        mode_next = mode_req_in.target;
      end else begin
        mode_refused_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_reg         <= rmst_pkg::MODE_REAL;
      mode_refused_reg <= 1'b0;
    end else begin
      mode_reg         <= mode_next;
      mode_refused_reg <= mode_refused_next;
    end
  end

  assign mode_out         = mode_reg;
  assign mode_refused_out = mode_refused_reg;

  // -----------------------------------------------------------------
  // load decode
  // -----------------------------------------------------------------
  wire logic mode_is_addr16;
  wire logic ld_user;
  wire logic ld_table;
  wire logic ld_sel_ok;
  wire logic ld_far_ok;
  wire logic ld_desc_ok;
  wire logic ld_shift;
  wire logic [3:0] ld_idx;
  logic      ld_refused_reg;

  assign mode_is_addr16 = mode_reg == rmst_pkg::MODE_REAL ||
                          mode_reg == rmst_pkg::MODE_V86;
  assign ld_user  = seg_ld_in.idx < 4'(rmst_pkg::NUM_USER);
  assign ld_table = seg_ld_in.idx == rmst_pkg::IDX_GLOBAL_DESCRIPTOR_TBL ||
                    seg_ld_in.idx == rmst_pkg::IDX_INTERRUPT_DESC_TBL;
  assign ld_sel_ok  = seg_ld_in.kind == rmst_pkg::LD_SELECTOR &&
                      mode_is_addr16 && ld_user;
  assign ld_far_ok  = seg_ld_in.kind == rmst_pkg::LD_FAR &&
                      mode_is_addr16;
  // descriptor-based loads need the tables, so they never land in
  // real or virtual-8086 mode; global and interrupt descriptor table base loads are always accepted
  assign ld_desc_ok = seg_ld_in.kind == rmst_pkg::LD_DESC &&
                      (ld_table || (!mode_is_addr16 &&
                       seg_ld_in.idx < 4'(rmst_pkg::NUM_SEGS)));
  assign ld_shift = seg_ld_in.valid && (ld_sel_ok || ld_far_ok);
  assign ld_idx   = ld_far_ok ? rmst_pkg::IDX_CODE_SEGMENT : seg_ld_in.idx;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ld_refused_reg <= 1'b0;
    end else begin
      ld_refused_reg <= seg_ld_in.valid && !ld_shift && !ld_desc_ok;
    end
  end

  assign ld_refused_out = ld_refused_reg;

  // -----------------------------------------------------------------
  // segment registers
  // -----------------------------------------------------------------
  rmst_pkg::rmst_seg_s seg_q [rmst_pkg::NUM_SEGS];

  for (genvar g = 0; g < rmst_pkg::NUM_SEGS; g++) begin : g_seg
    rmst_seg_slot u_slot (
      .clk_in     (clk_in),
      .rst_n_in   (rst_n_in),
      .ld_sel_in  (ld_shift && ld_idx == 4'(g)),
      .ld_desc_in (seg_ld_in.valid && ld_desc_ok &&
                   seg_ld_in.idx == 4'(g)),
      .val_in     (seg_ld_in.seg),
      .seg_out    (seg_q[g])
    );
  end

  // -----------------------------------------------------------------
  // address formation
  // -----------------------------------------------------------------
  wire logic                xl_user;
  wire logic                xl_aux;
  wire rmst_pkg::rmst_seg_s xl_seg;
  logic [63:0]              form_lin;
  logic                     form_fault;
  rmst_pkg::rmst_xlat_rsp_s rsp_reg;

  assign xl_user = xlat_req_in.idx < 4'(rmst_pkg::NUM_USER);
  assign xl_aux  = xlat_req_in.idx == rmst_pkg::IDX_AUX_SEGMENT_ONE ||
                   xlat_req_in.idx == rmst_pkg::IDX_AUX_SEGMENT_TWO;
  assign xl_seg  = xl_user ? seg_q[xlat_req_in.idx] : '0;

  rmst_addr_form u_form (
    .mode_in   (mode_reg),
    .seg_in    (xl_seg),
    .aux_in    (xl_aux),
    .ea_in     (xlat_req_in.ea),
    .lin_out   (form_lin),
    .fault_out (form_fault)
  );

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg.valid <= xlat_req_in.valid;
      rsp_reg.fault <= xlat_req_in.valid && (form_fault || !xl_user);
      rsp_reg.lin   <= form_lin;
    end
  end

  assign xlat_rsp_out = rsp_reg;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  wire logic [19:0]         exp_real;
  wire logic [31:0]         exp_legacy;
  wire rmst_pkg::rmst_seg_s ld_tgt;

  assign exp_real   = {xl_seg.sel, 4'h0} + {4'h0, xlat_req_in.ea[15:0]};
  assign exp_legacy = xl_seg.base[31:0] + xlat_req_in.ea[31:0];
  assign ld_tgt     = seg_ld_in.idx < 4'(rmst_pkg::NUM_SEGS) ?
                      seg_q[seg_ld_in.idx] : '0;

  a_real_exit_prot: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    ($past(mode_reg) == rmst_pkg::MODE_REAL && mode_reg != $past(mode_reg))
      |-> mode_reg == rmst_pkg::MODE_PROT)
    else $error("real mode left for a mode other than protected");

  a_real_addr_form: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (xlat_req_in.valid && xl_user && mode_reg == rmst_pkg::MODE_REAL)
      |=> xlat_rsp_out.valid &&
          xlat_rsp_out.lin == {44'h0, $past(exp_real)})
    else $error("real mode address is not selector*16 plus offset");

  a_sel_load_base: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (seg_ld_in.valid && seg_ld_in.kind == rmst_pkg::LD_SELECTOR &&
     mode_reg == rmst_pkg::MODE_REAL && ld_user)
      |=> seg_q[$past(seg_ld_in.idx)].sel == $past(seg_ld_in.seg.sel) &&
          seg_q[$past(seg_ld_in.idx)].base ==
            {44'h0, $past(seg_ld_in.seg.sel), 4'h0})
    else $error("selector load did not set base to selector*16");

  a_sel_load_keep: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (seg_ld_in.valid && seg_ld_in.kind == rmst_pkg::LD_SELECTOR &&
     mode_is_addr16 && ld_user)
      |=> seg_q[$past(seg_ld_in.idx)].limit == $past(ld_tgt.limit) &&
          seg_q[$past(seg_ld_in.idx)].attr == $past(ld_tgt.attr))
    else $error("selector load changed limit or attributes");

  a_far_code_base: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (seg_ld_in.valid && seg_ld_in.kind == rmst_pkg::LD_FAR &&
     mode_is_addr16)
      |=> seg_q[0].base == {44'h0, $past(seg_ld_in.seg.sel), 4'h0} &&
          $stable(seg_q[0].limit) && $stable(seg_q[0].attr))
    else $error("far transfer did not load code segment as selector*16");

  a_real_no_tables: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (seg_ld_in.valid && seg_ld_in.kind == rmst_pkg::LD_DESC &&
     mode_is_addr16 && !ld_table &&
     seg_ld_in.idx < 4'(rmst_pkg::NUM_SEGS))
      |=> ld_refused_out && seg_q[$past(seg_ld_in.idx)] == $past(ld_tgt))
    else $error("descriptor load accepted in real or v86 mode");

  a_v86_addr_form: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (xlat_req_in.valid && xl_user && mode_reg == rmst_pkg::MODE_V86)
      |=> xlat_rsp_out.lin[63:20] == 44'h0 &&
          xlat_rsp_out.lin[19:0] == $past(exp_real))
    else $error("v86 address not formed inside 1MB as in real mode");

  a_v86_intr_prot: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (intr_in && mode_reg == rmst_pkg::MODE_V86)
      |=> mode_reg == rmst_pkg::MODE_PROT && !mode_refused_out)
    else $error("interrupt in v86 mode did not enter protected mode");

  a_compat_legacy: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (xlat_req_in.valid && xl_user && mode_reg == rmst_pkg::MODE_COMPAT)
      |=> xlat_rsp_out.lin == {32'h0, $past(exp_legacy)})
    else $error("compatibility mode address differs from legacy form");

  a_flat_long64: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (xlat_req_in.valid && xl_user && !xl_aux &&
     mode_reg == rmst_pkg::MODE_LONG64)
      |=> xlat_rsp_out.lin == $past(xlat_req_in.ea) && !xlat_rsp_out.fault)
    else $error("64-bit mode address is not flat");

  a_aux_base_long64: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (xlat_req_in.valid && xl_aux && mode_reg == rmst_pkg::MODE_LONG64)
      |=> xlat_rsp_out.lin == $past(xlat_req_in.ea) + $past(xl_seg.base))
    else $error("auxiliary segment base not added in 64-bit mode");

  a_mode_refuse_hold: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (mode_req_in.valid && !req_legal &&
     !(mode_reg == rmst_pkg::MODE_V86 && intr_in))
      |=> mode_refused_out && mode_reg == $past(mode_reg))
    else $error("illegal mode request was not refused");

  a_prot_sel_refused: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (seg_ld_in.valid && seg_ld_in.kind == rmst_pkg::LD_SELECTOR &&
     !mode_is_addr16)
      |=> ld_refused_out)
    else $error("selector load accepted in a protected mode");

  a_desc_load_full: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (seg_ld_in.valid && ld_desc_ok &&
     seg_ld_in.idx < 4'(rmst_pkg::NUM_SEGS))
      |=> !ld_refused_out &&
          seg_q[$past(seg_ld_in.idx)] == $past(seg_ld_in.seg))
    else $error("descriptor load did not set base, limit and attributes");

  a_bad_idx_fault: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (xlat_req_in.valid && !xl_user)
      |=> xlat_rsp_out.valid && xlat_rsp_out.fault)
    else $error("translation through a non-user slot did not fault");

  a_sys_slot_long64: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (seg_ld_in.valid && seg_ld_in.kind == rmst_pkg::LD_DESC &&
     mode_reg == rmst_pkg::MODE_LONG64 &&
     seg_ld_in.idx >= 4'(rmst_pkg::NUM_USER) &&
     seg_ld_in.idx < 4'(rmst_pkg::NUM_SEGS))
      |=> !ld_refused_out &&
          seg_q[$past(seg_ld_in.idx)].base == $past(seg_ld_in.seg.base))
    else $error("system segment load refused in 64-bit mode");

endmodule // rmst_seg_xlat

`default_nettype wire

//--- rmst_pkg.sv
/*
  Package for the segment translation block: mode codes, segment slot
  indices, reset values, field widths and the packed carriers.
  Assumes a single clock domain and an execution path that drives
  synchronous, one-cycle requests.
*/
// Functional notes
// - the block starts in real mode; only protected mode is entered from it.
// - real address is 20 bits: selector shifted left four plus offset.
// - a real-mode pop or move load sets selector and base selector*16.
// - a real or virtual-8086 selector load keeps limit and attributes.
// - a real-mode far transfer loads code selector and base selector*16.
// - real mode never consults the descriptor tables or task state segment.
// - virtual-8086 mode forms bases as real mode does, inside a 1MB space.
// - v86 far transfers act as real; an interrupt enters protected mode.
// - compatibility mode segments exactly as legacy protected mode.
// - 64-bit mode is flat while the system segment registers stay in use.
// - there are ten segment registers, six user and four system.
// - each segment register holds a base, a limit and attributes.
// - in 64-bit mode bases count as zero, save the two auxiliary segments.
`default_nettype none

package rmst_pkg;

  // ---------------------------------------------------------------
  // widths and counts
  // ---------------------------------------------------------------
  localparam int SEL_W    = 16;
  localparam int BASE_W   = 64;
  localparam int LIMIT_W  = 32;
  localparam int ATTR_W   = 12;
  localparam int IDX_W    = 4;
  localparam int REAL_W   = 20;
  localparam int SHIFT_W  = 4;
  localparam int NUM_SEGS = 10;
  localparam int NUM_USER = 6;

  // ---------------------------------------------------------------
  // segment slot indices
  // ---------------------------------------------------------------
  localparam logic [3:0] IDX_CODE_SEGMENT          = 4'h0;
  localparam logic [3:0] IDX_DATA_SEGMENT_REG      = 4'h1;
  localparam logic [3:0] IDX_EXTRA_SEGMENT_REG     = 4'h2;
  localparam logic [3:0] IDX_AUX_SEGMENT_ONE       = 4'h3;
  localparam logic [3:0] IDX_AUX_SEGMENT_TWO       = 4'h4;
  localparam logic [3:0] IDX_STACK_SEGMENT         = 4'h5;
  localparam logic [3:0] IDX_GLOBAL_DESCRIPTOR_TBL = 4'h6;
  localparam logic [3:0] IDX_LOCAL_DESCRIPTOR_TBL  = 4'h7;
  localparam logic [3:0] IDX_INTERRUPT_DESC_TBL    = 4'h8;
  localparam logic [3:0] IDX_TASK_REGISTER         = 4'h9;

  // ---------------------------------------------------------------
  // reset values: 64K limit, read/write data
  // ---------------------------------------------------------------
  localparam logic [15:0] SEL_RESET   = 16'h0000;
  localparam logic [63:0] BASE_RESET  = 64'h0;
  localparam logic [31:0] LIMIT_RESET = 32'h0000_ffff;
  localparam logic [11:0] ATTR_RESET  = 12'h093;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_REAL   = 3'h0,
    MODE_PROT   = 3'h1,
    MODE_V86    = 3'h3,
    MODE_COMPAT = 3'h2,
    MODE_LONG64 = 3'h6
  } rmst_mode_e;

  typedef enum logic [1:0] {
    LD_SELECTOR = 2'h0,
    LD_FAR      = 2'h1,
    LD_DESC     = 2'h2
  } rmst_ld_kind_e;

  typedef struct packed {
    logic [15:0] sel;
    logic [63:0] base;
    logic [31:0] limit;
    logic [11:0] attr;
  } rmst_seg_s;

  typedef struct packed {
    logic          valid;
    rmst_ld_kind_e kind;
    logic [3:0]    idx;
    rmst_seg_s     seg;
  } rmst_ld_s;

  typedef struct packed {
    logic       valid;
    rmst_mode_e target;
  } rmst_mode_req_s;

  typedef struct packed {
    logic        valid;
    logic [3:0]  idx;
    logic [63:0] ea;
  } rmst_xlat_req_s;

  typedef struct packed {
    logic        valid;
    logic        fault;
    logic [63:0] lin;
  } rmst_xlat_rsp_s;

endpackage

`default_nettype wire

//--- rmst_seg_slot.sv
/*
  One segment register: selector, base, limit and attributes.
  Assumes the owner raises at most one load enable per cycle.
*/
`default_nettype none

module rmst_seg_slot (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // loads
  input  wire logic              ld_sel_in,
  input  wire logic              ld_desc_in,
  input  wire rmst_pkg::rmst_seg_s val_in,
  // contents
  output var  rmst_pkg::rmst_seg_s seg_out
);

  rmst_pkg::rmst_seg_s seg_reg;
  rmst_pkg::rmst_seg_s seg_next;
  wire logic [63:0]    shifted_base;

  assign shifted_base = {44'h0, val_in.sel, 4'h0};
  assign seg_out      = seg_reg;

  always_comb begin
    seg_next = seg_reg;
    if (ld_desc_in) begin
      seg_next = val_in;
    end else if (ld_sel_in) begin
      seg_next.sel  = val_in.sel;
      seg_next.base = shifted_base;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      seg_reg <= {rmst_pkg::SEL_RESET, rmst_pkg::BASE_RESET,
                  rmst_pkg::LIMIT_RESET, rmst_pkg::ATTR_RESET};
    end else begin
      seg_reg <= seg_next;
    end
  end

endmodule // rmst_seg_slot

`default_nettype wire

//--- rmst_addr_form.sv
/*
  Combinational linear address formation for one request.
  Assumes the owner registers the result.
*/
`default_nettype none

module rmst_addr_form (
  // request
  input  wire rmst_pkg::rmst_mode_e mode_in,
  input  wire rmst_pkg::rmst_seg_s  seg_in,
  input  wire logic                 aux_in,
  input  wire logic [63:0]          ea_in,
  // result
  output logic [63:0]               lin_out,
  output logic                      fault_out
);

  wire logic [19:0] real_sum;
  wire logic [31:0] legacy_sum;
  wire logic [63:0] flat_base;
  wire logic        legacy_fault;

  assign real_sum     = {seg_in.sel, 4'h0} + {4'h0, ea_in[15:0]};
  assign legacy_sum   = seg_in.base[31:0] + ea_in[31:0];
  assign flat_base    = aux_in ? seg_in.base : 64'h0;
  assign legacy_fault = ea_in[31:0] > seg_in.limit;

  always_comb begin
    lin_out   = 64'h0;
    fault_out = 1'b0;
    unique case (mode_in)
      rmst_pkg::MODE_REAL, rmst_pkg::MODE_V86: begin
        lin_out   = {44'h0, real_sum};
        fault_out = legacy_fault;
      end
      rmst_pkg::MODE_PROT, rmst_pkg::MODE_COMPAT: begin
        lin_out   = {32'h0, legacy_sum};
        fault_out = legacy_fault;
      end
      rmst_pkg::MODE_LONG64: begin
        lin_out   = ea_in + flat_base;
      end
      default: begin
        lin_out   = 64'h0;
        fault_out = 1'b1;
      end
    endcase
  end

endmodule // rmst_addr_form

`default_nettype wire

//--- rmst_exec_model.sv
/*
  Execution-path model: issues one-cycle request strobes from falling
  clock edges and then releases them.
  Assumes the block samples its inputs on the rising edge.
*/
`default_nettype none

module rmst_exec_model (
  // clock
  input  wire logic                     clk_in,
  // requests
  output var  rmst_pkg::rmst_mode_req_s mode_req_out,
  output var  logic                     intr_out,
  output var  rmst_pkg::rmst_ld_s       seg_ld_out,
  output var  rmst_pkg::rmst_xlat_req_s xlat_req_out
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    mode_req_out = '0;
    intr_out = 1'h0;
    seg_ld_out = '0;
    xlat_req_out = '0;
  end

  // one strobe cycle; released fields carry the inverse, not stale data
  task automatic cyc(input rmst_pkg::rmst_mode_req_s m, input logic i,
                     input rmst_pkg::rmst_ld_s l,
                     input rmst_pkg::rmst_xlat_req_s x);
    rmst_pkg::rmst_mode_req_s mz;
    rmst_pkg::rmst_ld_s       lz;
    rmst_pkg::rmst_xlat_req_s xz;
    mz = ~m;
    mz.valid = 1'h0;
    lz = ~l;
    lz.valid = 1'h0;
    xz = ~x;
    xz.valid = 1'h0;
    @(negedge clk_in);
    mode_req_out <= m;
    intr_out <= i;
    seg_ld_out <= l;
    xlat_req_out <= x;
    @(negedge clk_in);
    mode_req_out <= mz;
    intr_out <= 1'h0;
    seg_ld_out <= lz;
    xlat_req_out <= xz;
  endtask
endmodule // rmst_exec_model

`default_nettype wire

//--- tb.sv
/*
  Self-checking bench for the segment translation block.
  Assumes fixed one-cycle answers; every check but the one in reset is taken
  at the falling edge that follows the rising edge which took the request.
*/
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam rmst_pkg::rmst_ld_kind_e KS = rmst_pkg::LD_SELECTOR;
  localparam rmst_pkg::rmst_ld_kind_e KF = rmst_pkg::LD_FAR;
  localparam rmst_pkg::rmst_ld_kind_e KD = rmst_pkg::LD_DESC;
  localparam rmst_pkg::rmst_mode_e    MR = rmst_pkg::MODE_REAL;
  localparam rmst_pkg::rmst_mode_e    MP = rmst_pkg::MODE_PROT;
  localparam rmst_pkg::rmst_mode_e    MV = rmst_pkg::MODE_V86;
  localparam rmst_pkg::rmst_mode_e    MC = rmst_pkg::MODE_COMPAT;
  localparam rmst_pkg::rmst_mode_e    ML = rmst_pkg::MODE_LONG64;
  logic                     clk_in;
  logic                     rst_n_in;
  rmst_pkg::rmst_mode_req_s mode_req;
  logic                     intr;
  rmst_pkg::rmst_ld_s       seg_ld;
  rmst_pkg::rmst_xlat_req_s xlat_req;
  rmst_pkg::rmst_xlat_rsp_s rsp;
  rmst_pkg::rmst_mode_e     mode;
  logic                     mode_ref;
  logic                     ld_ref;
  int                       failures;
  int                       total_checks;

  rmst_seg_xlat rmst_seg_xlat_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .mode_req_in(mode_req), .intr_in(intr), .seg_ld_in(seg_ld),
    .xlat_req_in(xlat_req), .xlat_rsp_out(rsp), .mode_out(mode),
    .mode_refused_out(mode_ref), .ld_refused_out(ld_ref));

  rmst_exec_model rmst_exec_model_inst (.clk_in(clk_in),
    .mode_req_out(mode_req), .intr_out(intr), .seg_ld_out(seg_ld),
    .xlat_req_out(xlat_req));

  initial begin
    clk_in = 1'h0;
    forever #50 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [63:0] e, g);
    total_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic do_reset();
    rst_n_in <= 1'h0;
    repeat (6) @(negedge clk_in);
    chk("mode_in_reset", MR, mode);
    rst_n_in <= 1'h1;
  endtask

  task automatic do_m(input rmst_pkg::rmst_mode_e t, e, input logic r,
                      input logic i);
    rmst_exec_model_inst.cyc('{1'h1, t}, i, '0, '0);
    chk("mode", e, mode);
    chk("mode_refused", r, mode_ref);
  endtask

  task automatic do_ld(input rmst_pkg::rmst_ld_kind_e k,
                       input logic [3:0] i, input logic [15:0] s,
                       input logic [63:0] b, input logic [31:0] lm,
                       input logic r);
    rmst_exec_model_inst.cyc('0, 1'h0, '{1'h1, k, i, '{s, b, lm, 12'h093}},
                             '0);
    chk("ld_refused", r, ld_ref);
  endtask

  task automatic do_x(input logic [3:0] i, input logic [63:0] ea, el,
                      input logic f);
    rmst_exec_model_inst.cyc('0, 1'h0, '0, '{1'h1, i, ea});
    chk("rsp_valid", 1'h1, rsp.valid);
    chk("rsp_fault", f, rsp.fault);
    if (!f) begin
      chk("rsp_lin", el, rsp.lin);
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_real_start();
    do_x(4'h1, 64'h5, 64'h5, 1'h0);
    do_m(MV, MR, 1'h1, 1'h0);
    do_m(ML, MR, 1'h1, 1'h0);
    do_m(MR, MR, 1'h1, 1'h1);
  endtask

  task automatic s_real_load();
    for (int i = 0; i < 6; i++) begin
      do_ld(KS, 4'(i), 16'h1234 + 16'(i), 64'h0, 32'h0, 1'h0);
      do_x(4'(i), 64'h5, 64'h12345 + 64'(i * 16), 1'h0);
    end
    do_x(4'h2, 64'hffff, 64'h2235f, 1'h0);
    do_x(4'h2, 64'h10000, 64'h0, 1'h1);
    do_ld(KS, 4'h5, 16'hffff, 64'h0, 32'h0, 1'h0);
    do_x(4'h5, 64'h20, 64'h10, 1'h0);
  endtask

  task automatic s_real_far();
    do_ld(KF, 4'h3, 16'habcd, 64'h0, 32'h0, 1'h0);
    do_x(4'h0, 64'h1, 64'habcd1, 1'h0);
    do_x(4'h3, 64'h1, 64'h12371, 1'h0);
    do_x(4'h0, 64'h10000, 64'h0, 1'h1);
  endtask

  task automatic s_real_refuse();
    do_ld(KD, 4'h7, 16'h8, 64'h5000, 32'hffff, 1'h1);
    do_ld(KD, 4'h9, 16'h8, 64'h5000, 32'hffff, 1'h1);
    do_ld(KD, 4'h1, 16'h8, 64'h5000, 32'hffff, 1'h1);
    do_ld(KD, 4'h6, 16'h8, 64'h5000, 32'hffff, 1'h0);
    do_ld(KS, 4'h6, 16'h8, 64'h0, 32'h0, 1'h1);
    do_ld(KS, 4'ha, 16'h8, 64'h0, 32'h0, 1'h1);
    do_x(4'h1, 64'h5, 64'h12355, 1'h0);
    do_x(4'h6, 64'h5, 64'h0, 1'h1);
  endtask

  task automatic s_v86();
    do_m(MP, MP, 1'h0, 1'h0);
    do_m(MV, MV, 1'h0, 1'h0);
    do_ld(KS, 4'h2, 16'h0010, 64'h0, 32'h0, 1'h0);
    do_x(4'h2, 64'h5, 64'h105, 1'h0);
    do_x(4'h2, 64'h10000, 64'h0, 1'h1);
    do_ld(KF, 4'h0, 16'h0020, 64'h0, 32'h0, 1'h0);
    do_x(4'h0, 64'h5, 64'h205, 1'h0);
    do_ld(KD, 4'h7, 16'h8, 64'h0, 32'hffff, 1'h1);
    do_m(MV, MP, 1'h0, 1'h1);
  endtask

  task automatic s_prot_long();
    do_ld(KS, 4'h1, 16'h8, 64'h0, 32'h0, 1'h1);
    do_ld(KD, 4'h1, 16'h8, 64'h1_0000_2000, 32'hffff_ffff, 1'h0);
    do_x(4'h1, 64'h10, 64'h2010, 1'h0);
    do_ld(KD, 4'h2, 16'h10, 64'h0, 32'h0fff, 1'h0);
    do_x(4'h2, 64'h1000, 64'h0, 1'h1);
    do_m(MC, MC, 1'h0, 1'h0);
    do_x(4'h1, 64'h10, 64'h2010, 1'h0);
    do_m(ML, ML, 1'h0, 1'h0);
    do_x(4'h1, 64'h1234_5678_9abc_def0, 64'h1234_5678_9abc_def0,
         1'h0);
    do_x(4'h2, 64'h1000, 64'h1000, 1'h0);
    do_ld(KD, 4'h4, 16'h18, 64'h1_0000_0000, 32'h0, 1'h0);
    do_x(4'h4, 64'h20, 64'h1_0000_0020, 1'h0);
    do_ld(KD, 4'h9, 16'h20, 64'h9000, 32'h67, 1'h0);
    do_m(MR, ML, 1'h1, 1'h0);
  endtask

  task automatic s_reset_again();
    do_reset();
    do_x(4'h4, 64'h5, 64'h5, 1'h0);
    do_m(MV, MR, 1'h1, 1'h0);
  endtask

  // ----------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    failures = 0;
    total_checks = 0;
    rst_n_in = 1'h0;
    do_reset();
    s_real_start();
    s_real_load();
    s_real_far();
    s_real_refuse();
    s_v86();
    s_prot_long();
    s_reset_again();
    conclude();
  end

  initial begin
    repeat (5000) @(posedge clk_in);
    failures++;
    conclude();
  end
endmodule // tb

`default_nettype wire
